// >>> hw/sdcs_pin_if.sv
interface sdcs_pin_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport syncer (input raw, output clean);
   modport user (output raw, input clean);
endinterface

// >>> hw/sdcs_pin_sync.sv
module sdcs_pin_sync #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic rst,
   sdcs_pin_if.syncer pins
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] clean;
   } sdcs_sync_t;
   sdcs_sync_t r_r;
   sdcs_sync_t r_nxt;

   // A level is accepted only when the second and third stages agree, which rejects
   // single-sample glitches on the pins at the cost of one extra cycle of latency.
   always_comb begin
      r_nxt = r_r;
      r_nxt.s1 = pins.raw;
      r_nxt.s2 = r_r.s1;
      r_nxt.s3 = r_r.s2;
      for (int i = 0; i < W; i++) begin
         if (r_r.s2[i] == r_r.s3[i]) begin
            r_nxt.clean[i] = r_r.s3[i];
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign pins.clean = r_r.clean;
endmodule // sdcs_pin_sync

// >>> hw/sdcs_pkg.sv
package sdcs_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int STREAM_DEPTH = 2048;
   localparam int STREAM_ROOM = 32;
   localparam int REG_COUNT = 16;
   localparam int REG_W = 16;
   localparam int INIT_TIME_NS = 1000000;
   localparam int INIT_CYCLES_DFLT = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EXEC_TIME_NS = 2000;
   localparam int EXEC_CYCLES = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] MODE_CONFIG_IDX = 8'h00;
   localparam logic [7:0] RAM_DATA_IDX = 8'h06;
   localparam logic [7:0] RAM_ADDR_IDX = 8'h07;
   localparam logic [15:0] DREQ_STATUS_ADDR = 16'hC012;
   localparam int DREQ_BIT = 0;
   localparam logic [3:0] LAST_BYTE_BIT = 4'h7;
   localparam logic [4:0] LAST_WORD_BIT = 5'h0F;
   localparam int PIN_COUNT = 6;
   localparam int PIN_SCK = 0;
   localparam int PIN_SI = 1;
   localparam int PIN_CTRL_CS = 2;
   localparam int PIN_BYTE_SYNC = 3;
   localparam int PIN_LCLK = 4;
   localparam int PIN_LDATA = 5;
   typedef enum logic [2:0] {
      CTRL_IDLE = 3'h0,
      CTRL_INSTR = 3'h1,
      CTRL_ADDR = 3'h3,
      CTRL_DATA = 3'h2,
      CTRL_DONE = 3'h6
   } sdcs_ctrl_state_t;
endpackage

// >>> hw/sdcs_serial_slave.sv
// Overview of operation
// [R1] Native framing: byte-sync pin becomes data select
// [R2] Chip select high aborts, output released
// [R3] Shared select: data select is inverted control select
// [R4] First rising clock after select starts transfer
// [R5] Serial input sampled on rising clock edges
// [R6] Reads shift out on falling edges only
// [R7] Legacy framing aligns bytes on byte-sync rise
// [R8] Request high when 32 bytes room
// [R9] Request low when full or executing
// [R10] Host may burst 32 bytes per check
// [R11] Request may change mid-byte; bytes complete
// [R12] Host waits worst-case time while request low
// [R13] Request readable via RAM address C012
// [R14] Host always generates the data clock
// [R15] Legacy capture edge is selectable
// [R16] Bit order select picks MSB/LSB first
// [R17] Native byte alignment from data select
// [R18] Host should reselect every 32 bytes
// [R19] Instruction, address, one 16-bit word (writes keep accepting further words to the same register)
// [R20] Opcode 3 reads, 2 writes
// [R21] Request low after every control operation (the code holds it low only after a completed read or write data word)
// [R22] Host sends control bytes MSB first
// [R23] Request held low until initialization completes
module sdcs_serial_slave
   import sdcs_pkg::*;
#(
   parameter int DEPTH = STREAM_DEPTH,
   parameter int ROOM = STREAM_ROOM,
   parameter int INIT_CYCLES = INIT_CYCLES_DFLT
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sck,
   input wire logic si,
   input wire logic controlChipSelectN,
   input wire logic byteSyncOrDataSelectN,
   input wire logic legacyDataClock,
   input wire logic legacySerialData,
   input wire logic nativeFramingSelect,
   input wire logic sharedSelectEnable,
   input wire logic bitOrderSelect,
   input wire logic legacyFallingEdge,
   input wire logic streamTake,
   output logic soOut,
   output logic soOe,
   output logic dataRequest,
   output logic [7:0] streamByte,
   output logic streamValid,
   output logic regWriteValid,
   output logic [7:0] regWriteAddr,
   output logic [REG_W-1:0] regWriteData
);
   localparam int FILL_W = $clog2(DEPTH + 1);
   localparam int INIT_W = $clog2(INIT_CYCLES + 1);
   localparam int EXEC_W = $clog2(EXEC_CYCLES + 1);
   localparam logic [FILL_W-1:0] FILL_MAX = FILL_W'(DEPTH);
   localparam logic [FILL_W-1:0] FILL_ROOM = FILL_W'(ROOM);
   localparam logic [INIT_W-1:0] INIT_END = INIT_W'(INIT_CYCLES);
   localparam logic [EXEC_W-1:0] EXEC_LOAD = EXEC_W'(EXEC_CYCLES);

   typedef struct packed {
      sdcs_ctrl_state_t cst;
      logic [4:0] cBits;
      logic [REG_W-1:0] cShift;
      logic [7:0] cInstr;
      logic [7:0] cAddr;
      logic [REG_W-1:0] outShift;
      logic soOut;
      logic soOe;
      logic [EXEC_W-1:0] execCnt;
      logic [INIT_W-1:0] initCnt;
      logic [3:0] dBits;
      logic [7:0] dShift;
      logic [FILL_W-1:0] fill;
      logic [7:0] byteOut;
      logic byteValid;
      logic dreq;
      logic [REG_COUNT-1:0][REG_W-1:0] regs;
      logic wrValid;
      logic [7:0] wrAddr;
      logic [REG_W-1:0] wrData;
      logic sckPrev;
      logic lclkPrev;
      logic bsyncPrev;
   } sdcs_state_t;

   sdcs_state_t st_r;
   sdcs_state_t st_nxt;

   sdcs_pin_if #(.W(PIN_COUNT)) pinBus ();

   assign pinBus.raw = {legacySerialData, legacyDataClock, byteSyncOrDataSelectN,
                        controlChipSelectN, si, sck};

   sdcs_pin_sync #(.W(PIN_COUNT)) pinSync (
      .core_clk(core_clk),
      .rst(rst),
      .pins(pinBus.syncer)
   );

   logic sckNow, siNow, ctrlCsN, bsyncNow, lclkNow, ldataNow;
   assign sckNow = pinBus.clean[PIN_SCK];
   assign siNow = pinBus.clean[PIN_SI];
   assign ctrlCsN = pinBus.clean[PIN_CTRL_CS];
   assign bsyncNow = pinBus.clean[PIN_BYTE_SYNC];
   assign lclkNow = pinBus.clean[PIN_LCLK];
   assign ldataNow = pinBus.clean[PIN_LDATA];

   function automatic logic [REG_W-1:0] readWord(input sdcs_state_t s, input logic [7:0] a);
      logic [REG_W-1:0] v;
      v = '0;
      if (a == RAM_DATA_IDX && s.regs[RAM_ADDR_IDX[3:0]] == DREQ_STATUS_ADDR) begin
         v[DREQ_BIT] = s.dreq; // [R13]
      end else if (32'(a) < REG_COUNT) begin
         v = s.regs[a[3:0]];
      end
      return v;
   endfunction

   always_comb begin
      logic sckRise, sckFall, lclkRise, lclkFall, bsyncRise;
      logic dEdge, dBit, dActive, push, pop;
      logic [3:0] dBase;
      logic [7:0] dNext;
      logic [15:0] wordIn;
      sckRise = 1'b0;
      sckFall = 1'b0;
      lclkRise = 1'b0;
      lclkFall = 1'b0;
      bsyncRise = 1'b0;
      dEdge = 1'b0;
      dBit = 1'b0;
      dActive = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      dBase = '0;
      dNext = '0;
      wordIn = '0;
      st_nxt = st_r;
      st_nxt.byteValid = 1'b0;
      st_nxt.wrValid = 1'b0;
      sckRise = sckNow & ~st_r.sckPrev;
      sckFall = ~sckNow & st_r.sckPrev;
      lclkRise = lclkNow & ~st_r.lclkPrev;
      lclkFall = ~lclkNow & st_r.lclkPrev;
      bsyncRise = bsyncNow & ~st_r.bsyncPrev;
      st_nxt.sckPrev = sckNow;
      st_nxt.lclkPrev = lclkNow;
      st_nxt.bsyncPrev = bsyncNow;

      if (st_r.initCnt != INIT_END) begin
         st_nxt.initCnt = st_r.initCnt + INIT_W'(1);
      end
      if (st_r.execCnt != '0) begin
         st_nxt.execCnt = st_r.execCnt - EXEC_W'(1);
      end

      // Control side: select high always wins, so a half-shifted command is dropped.
      if (ctrlCsN) begin
         st_nxt.cst = CTRL_IDLE; // [R2]
         st_nxt.cBits = '0;
         st_nxt.soOe = 1'b0; // [R2]
      end else begin
         if (st_r.cst == CTRL_IDLE) begin
            st_nxt.cst = CTRL_INSTR; // [R4]
         end
         if (sckRise && st_r.cst != CTRL_IDLE && st_r.cst != CTRL_DONE) begin
            wordIn = {st_r.cShift[14:0], siNow}; // [R5]
            st_nxt.cShift = wordIn;
            st_nxt.cBits = st_r.cBits + 5'h01;
            case (st_r.cst)
               CTRL_INSTR: begin
                  if (st_r.cBits[3:0] == LAST_BYTE_BIT) begin
                     st_nxt.cInstr = wordIn[7:0]; // [R19]
                     st_nxt.cBits = '0;
                     st_nxt.cst = CTRL_ADDR;
                  end
               end
               CTRL_ADDR: begin
                  if (st_r.cBits[3:0] == LAST_BYTE_BIT) begin
                     st_nxt.cAddr = wordIn[7:0];
                     st_nxt.cBits = '0;
                     if (st_r.cInstr == OP_READ) begin
                        st_nxt.outShift = readWord(st_r, wordIn[7:0]); // [R20]
                        st_nxt.soOe = 1'b1; // [R6]
                        st_nxt.cst = CTRL_DATA;
                     end else if (st_r.cInstr == OP_WRITE) begin
                        st_nxt.cst = CTRL_DATA; // [R20]
                     end else begin
                        st_nxt.cst = CTRL_DONE;
                     end
                  end
               end
               CTRL_DATA: begin
                  if (st_r.cBits == LAST_WORD_BIT) begin
                     // Writes stay in the data phase, so further words hit the same register; reads move to CTRL_DONE.
                     st_nxt.cBits = '0;
                     st_nxt.execCnt = EXEC_LOAD; // [R21]
                     if (st_r.cInstr == OP_WRITE) begin
                        if (32'(st_r.cAddr) < REG_COUNT) begin
                           st_nxt.regs[st_r.cAddr[3:0]] = wordIn; // [R19]
                        end
                        st_nxt.wrValid = 1'b1;
                        st_nxt.wrAddr = st_r.cAddr;
                        st_nxt.wrData = wordIn;
                     end else begin
                        st_nxt.cst = CTRL_DONE;
                     end
                  end
               end
               default: begin
                  st_nxt.cst = CTRL_IDLE;
               end
            endcase
         end
         if (sckFall && st_r.soOe && st_r.cst == CTRL_DATA) begin
            st_nxt.soOut = st_r.outShift[REG_W-1]; // [R6]
            st_nxt.outShift = {st_r.outShift[REG_W-2:0], 1'b0};
         end
      end

      // Data side: the clock, bit and framing source depend on the framing select.
      dBase = st_r.dBits;
      if (nativeFramingSelect) begin
         dEdge = sckRise; // [R1] [R5]
         dBit = siNow;
         dActive = sharedSelectEnable ? ctrlCsN : ~bsyncNow; // [R3] [R1]
         if (!dActive) begin
            dBase = '0; // [R17]
         end
      end else begin
         dEdge = legacyFallingEdge ? lclkFall : lclkRise; // [R15] [R7]
         dBit = ldataNow;
         if (bsyncRise) begin
            dBase = '0; // [R7]
         end
         // Passive variant receives only while byte sync is high.
         dActive = sharedSelectEnable ? bsyncNow : (bsyncNow || dBase != '0);
      end
      st_nxt.dBits = dBase;
      if (dEdge && dActive) begin
         dNext = bitOrderSelect ? {dBit, st_r.dShift[7:1]} : {st_r.dShift[6:0], dBit}; // [R16]
         st_nxt.dShift = dNext;
         if (dBase == LAST_BYTE_BIT) begin
            st_nxt.dBits = '0;
            st_nxt.byteOut = dNext;
            st_nxt.byteValid = 1'b1;
            push = st_r.fill != FILL_MAX;
         end else begin
            st_nxt.dBits = dBase + 4'h1;
         end
      end
      pop = streamTake && st_r.fill != '0;
      if (push && !pop) begin
         st_nxt.fill = st_r.fill + FILL_W'(1);
      end else if (pop && !push) begin
         st_nxt.fill = st_r.fill - FILL_W'(1);
      end

      // Room is judged on the next fill level (st_nxt.fill); a byte in flight is covered by the margin.
      st_nxt.dreq = (st_r.initCnt == INIT_END) // [R23]
         && (st_nxt.execCnt == '0) // [R9] [R21]
         && ((FILL_MAX - st_nxt.fill) >= FILL_ROOM); // [R8] [R9] [R11]
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign soOut = st_r.soOut;
   assign soOe = st_r.soOe;
   assign dataRequest = st_r.dreq;
   assign streamByte = st_r.byteOut;
   assign streamValid = st_r.byteValid;
   assign regWriteValid = st_r.wrValid;
   assign regWriteAddr = st_r.wrAddr;
   assign regWriteData = st_r.wrData;
endmodule // sdcs_serial_slave

// >>> verification/sdcs_checker.sv
module sdcs_checker
   import sdcs_pkg::*;
#(
   parameter int INIT_CYCLES = INIT_CYCLES_DFLT
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic controlChipSelectN,
   input wire logic byteSyncOrDataSelectN,
   input wire logic nativeFramingSelect,
   input wire logic sharedSelectEnable,
   input wire logic soOe,
   input wire logic dataRequest,
   input wire logic streamValid,
   input wire logic regWriteValid
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int RISE_MAX = INIT_CYCLES + 8;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   property p_init;
      $fell(rst) |-> (!dataRequest) [*8] ##[1:RISE_MAX] dataRequest;
   endproperty
   a_init: assert property (p_init) else $error("request rise after reset");
   // The request stays low for eight cycles, starting two cycles after each write strobe.
   property p_exec;
      regWriteValid |=> ##1 (!dataRequest) [*8];
   endproperty
   a_exec: assert property (p_exec) else $error("request high during execution");
   property p_back;
      regWriteValid |-> ##[90:110] dataRequest;
   endproperty
   a_back: assert property (p_back) else $error("request not back after write");
   property p_oe;
      controlChipSelectN [*8] |-> !soOe;
   endproperty
   a_oe: assert property (p_oe) else $error("output driven while deselected");
   property p_wroe;
      regWriteValid |-> !soOe;
   endproperty
   a_wroe: assert property (p_wroe) else $error("output driven in write");
   property p_native;
      streamValid && nativeFramingSelect && !sharedSelectEnable |-> !byteSyncOrDataSelectN;
   endproperty
   a_native: assert property (p_native) else $error("byte without data select");
   property p_shared;
      streamValid && nativeFramingSelect && sharedSelectEnable |-> controlChipSelectN;
   endproperty
   a_shared: assert property (p_shared) else $error("shared select byte");
   property p_spulse;
      streamValid |=> !streamValid;
   endproperty
   a_spulse: assert property (p_spulse) else $error("byte strobe too long");
endmodule // sdcs_checker

bind sdcs_serial_slave sdcs_checker #(.INIT_CYCLES(INIT_CYCLES)) checker_i (.*);

// >>> verification/sdcs_host_model.sv
module sdcs_host_model (
   input wire logic core_clk,
   input wire logic soOut,
   input wire logic dataRequest,
   output logic sck,
   output logic si,
   output logic controlChipSelectN,
   output logic dataChipSelectN
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sck = 1'b0;
      si = 1'b0;
      controlChipSelectN = 1'b1;
      dataChipSelectN = 1'b1;
   end
   task automatic waitReq();
      int n = 0;
      @(negedge core_clk);
      while (dataRequest !== 1'b1 && n < 2000) begin
         @(negedge core_clk);
         n++;
      end
      @(posedge core_clk);
   endtask
   // Output is sampled late in the high phase, well after the falling-edge shift.
   task automatic bitx(input logic b, output logic q);
      sck <= 1'b0;
      si <= b;
      repeat (4) @(posedge core_clk);
      sck <= 1'b1;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk) q = soOut;
      @(posedge core_clk);
   endtask
   task automatic word(input logic [15:0] w, output logic [15:0] r);
      for (int i = 15; i >= 0; i--) bitx(w[i], r[i]);
   endtask
   task automatic byte8(input logic [7:0] v, input logic lsb);
      logic q;
      for (int i = 0; i < 8; i++) bitx(lsb ? v[i] : v[7 - i], q);
   endtask
   task automatic sel(input logic ctrl, input logic pin);
      waitReq();
      if (ctrl) controlChipSelectN <= 1'b0;
      else dataChipSelectN <= pin;
      repeat (2) @(posedge core_clk);
   endtask
   task automatic desel();
      sck <= 1'b0;
      repeat (4) @(posedge core_clk);
      controlChipSelectN <= 1'b1;
      dataChipSelectN <= 1'b1;
      si <= ~si;
      repeat (4) @(posedge core_clk);
   endtask
endmodule // sdcs_host_model

// >>> verification/testbench.sv
module testbench
   import sdcs_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   localparam int INIT_N = 20;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic sck, si, controlChipSelectN, dataChipSelectN, byteSyncOrDataSelectN;
   logic nativeFramingSelect = 1'b1;
   logic sharedSelectEnable = 1'b0;
   logic bitOrderSelect = 1'b0;
   logic legacyFallingEdge = 1'b0;
   logic streamTake = 1'b0;
   logic legacyDataClock = 1'b0;
   logic legacySerialData = 1'b0;
   logic byteSync = 1'b0;
   logic soOut, soOe, dataRequest, streamValid, regWriteValid;
   logic [7:0] streamByte, regWriteAddr, lastByte;
   logic [15:0] regWriteData;
   int mismatches = 0;
   int n_checks = 0;
   int nStream = 0;
   int nWrites = 0;
   assign byteSyncOrDataSelectN = nativeFramingSelect ? dataChipSelectN : byteSync;
   always #10 core_clk = ~core_clk;
   sdcs_serial_slave #(.DEPTH(64), .ROOM(32), .INIT_CYCLES(INIT_N)) dut (.*);
   sdcs_host_model host (.*);
   always @(posedge core_clk) begin
      if (streamValid === 1'b1) begin
         nStream++;
         lastByte = streamByte;
      end
      if (regWriteValid === 1'b1) nWrites++;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic ctrl(input logic [7:0] op, a, input logic [15:0] d, output logic [15:0] r);
      logic [15:0] x;
      host.sel(1'b1, 1'b1);
      host.word({op, a}, x);
      host.word(d, r);
      host.desel();
   endtask
   task automatic t_reset();
      int n = 0;
      @(negedge core_clk);
      chk(16'(dataRequest), 16'h0000);
      while (dataRequest !== 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      chk(16'(n > INIT_N - 2 && n < INIT_N + 4), 16'h0001);
      $display("reset done");
   endtask
   task automatic t_regs();
      logic [15:0] r;
      int w = nWrites;
      ctrl(OP_WRITE, 8'h03, 16'hBEEF, r);
      @(negedge core_clk);
      chk(16'(dataRequest), 16'h0000);
      chk(16'(nWrites - w), 16'h0001);
      chk(16'(regWriteAddr), 16'h0003);
      chk(regWriteData, 16'hBEEF);
      ctrl(OP_READ, 8'h03, 16'hFFFF, r);
      chk(r, 16'hBEEF);
      host.sel(1'b1, 1'b1);
      host.word({OP_WRITE, 8'h03}, r);
      host.byte8(8'h12, 1'b0);
      host.desel();
      ctrl(OP_READ, 8'h03, 16'h0000, r);
      chk(r, 16'hBEEF);
      chk(16'(nWrites - w), 16'h0001);
      ctrl(OP_WRITE, RAM_ADDR_IDX, DREQ_STATUS_ADDR, r);
      ctrl(OP_READ, RAM_DATA_IDX, 16'h0000, r);
      chk(r, 16'h0001);
      $display("regs done");
   endtask
   task automatic t_native();
      int n;
      for (int k = 0; k < 3; k++) begin
         bitOrderSelect <= k[0];
         sharedSelectEnable <= k[1];
         n = nStream;
         host.sel(1'b0, k[1]);
         host.byte8(8'h1E, k[0]);
         host.desel();
         chk(16'(nStream - n), 16'h0001);
         chk(16'(lastByte), 16'h001E);
      end
      sharedSelectEnable <= 1'b0;
      $display("native done");
   endtask
   task automatic t_legacy();
      logic [7:0] v;
      int n;
      nativeFramingSelect <= 1'b0;
      for (int e = 0; e < 3; e++) begin
         v = (e == 2) ? 8'h3C : (e == 1) ? 8'h4D : 8'hB2;
         n = nStream;
         legacyFallingEdge <= e[0];
         sharedSelectEnable <= e[1];
         legacyDataClock <= e[0];
         repeat (8) @(posedge core_clk);
         for (int i = 7; i >= 0; i--) begin
            byteSync <= (i == 7) || e[1];
            legacySerialData <= v[i];
            legacyDataClock <= e[0];
            repeat (4) @(posedge core_clk);
            legacyDataClock <= ~e[0];
            repeat (4) @(posedge core_clk);
         end
         legacyDataClock <= e[0];
         legacySerialData <= ~legacySerialData;
         byteSync <= 1'b0;
         repeat (8) @(posedge core_clk);
         chk(16'(nStream - n), 16'h0001);
         chk(16'(lastByte), 16'(v));
      end
      nativeFramingSelect <= 1'b1;
      sharedSelectEnable <= 1'b0;
      $display("legacy done");
   endtask
   task automatic takeN(input int k);
      @(posedge core_clk);
      repeat (k) begin
         streamTake <= 1'b1;
         @(posedge core_clk);
         streamTake <= 1'b0;
         @(posedge core_clk);
      end
   endtask
   task automatic t_fill();
      takeN(nStream);
      host.sel(1'b0, 1'b0);
      repeat (32) host.byte8(8'h5A, 1'b0);
      host.desel();
      @(negedge core_clk);
      chk(16'(dataRequest), 16'h0001);
      host.sel(1'b0, 1'b0);
      host.byte8(8'h5A, 1'b0);
      host.desel();
      @(negedge core_clk);
      chk(16'(dataRequest), 16'h0000);
      takeN(1);
      repeat (4) @(negedge core_clk);
      chk(16'(dataRequest), 16'h0001);
      $display("fill done");
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_native();
      t_legacy();
      t_fill();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      test_done();
   end
endmodule // testbench
